// ===== hw/pscc_pkg.sv
// Purpose: Constants for loop supervision and clock control
// Assumes: 200 MHz ref_clk, all inputs from other domains synchronised in the top
// Notes: Field layouts and analogue parts are outside this block
`default_nettype none
package pscc_pkg;
    // 200 MHz clock
    localparam int unsigned CLK_KHZ = 200000;
    // Too-low threshold
    localparam int unsigned OSC_LOW_KHZ = 300;
    // Window of internal 5 MHz clock edges for frequency check
    localparam int unsigned INT_KHZ = 5000;
    localparam int unsigned WATCH_WIN = 64;
    // Minimum crystal edges per window: 300 kHz over 64 edges of 5 MHz
    localparam int unsigned OSC_MIN_EDGES = (OSC_LOW_KHZ * WATCH_WIN + INT_KHZ - 1) / INT_KHZ;
    // Windows to pass before too-low status is valid
    localparam int unsigned WATCH_SETTLE = 2;
    // Lock detector: reference edges per window and allowed feedback miss
    localparam int unsigned LOCK_WIN = 32;
    localparam int unsigned LOCK_TOL = 2;
    localparam int unsigned LOCK_GOOD_WINS = 4;
    // Clock source select codes
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SRC_XTAL = 2'h1;
    localparam logic [1:0] SRC_LP = 2'h2;
    // Reference source select codes
    localparam logic [1:0] REF_INT = 2'h0;
    localparam logic [1:0] REF_XTAL = 2'h1;
    // Power-on defaults
    localparam logic [3:0] FB_DIV_RST = 4'h6;
    localparam logic [1:0] OUT_DIV_RST = 2'h0;
    localparam logic [3:0] SLOW_DIV_RST = 4'h0;
    typedef enum logic [1:0] {ST_BOOT, ST_WAIT_LOCK, ST_RUN} pscc_boot_type;
endpackage : pscc_pkg
`default_nettype wire

// ===== hw/pscc_top.sv
// Purpose: Loop supervision, trap flags and clock source control
// Assumes: Pulse inputs are one ref_clk cycle wide; edges of oscillators are sampled
// Notes: Clock gating is expressed as enable levels for the clock tree
`default_nettype none
module pscc_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    // Cold reset (power-on class); warm resets are not wired here
    input wire logic cold_rst_n,
    // Sampled oscillator edges from outside the domain
    input wire logic int_osc_in,
    input wire logic xtal_osc_in,
    input wire logic fb_clk_in,
    // Software control
    input wire logic wr_en,
    input wire logic wr_bypass,
    input wire logic wr_bypass_val,
    input wire logic wr_feedback,
    input wire logic [3:0] wr_feedback_val,
    input wire logic wr_ref_src,
    input wire logic [1:0] wr_ref_src_val,
    input wire logic wr_range,
    input wire logic wr_range_val,
    input wire logic wr_sys_src,
    input wire logic [1:0] wr_sys_src_val,
    input wire logic wr_slow,
    input wire logic [3:0] wr_slow_val,
    input wire logic slowdown_enable,
    input wire logic osc_watch_restart,
    input wire logic lock_detect_restart,
    input wire logic osc_trap_clear,
    input wire logic loop_trap_clear,
    input wire logic osc_trap_enable,
    input wire logic loop_trap_enable,
    input wire logic wake_up,
    // Status
    output logic osc_too_low_flag,
    output logic lock_flag,
    output logic vco_bypass_select,
    output logic osc_disconnect,
    output logic freerun_active,
    output logic [3:0] feedback_divider_field,
    output logic [1:0] ref_src_sel,
    output logic vco_range_select,
    output logic [1:0] sys_clock_source_sel,
    output logic [3:0] slowdown_divider,
    output logic osc_trap_flag,
    output logic loop_trap_flag,
    output logic osc_trap,
    output logic loop_trap,
    output logic lock_detect_restart_rd,
    output logic [3:0] cpu_div_sel,
    output logic periph_clock_a_en,
    output logic periph_clock_b_en,
    output logic memory_clock_en
);
    // ***********************************
    // Synchronisers
    // ***********************************
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {fb_clk_in, xtal_osc_in, int_osc_in};
            sync2_q <= sync1_q;
        end
    end

    // ***********************************
    // State
    // ***********************************
    typedef struct packed {
        logic [2:0] last;
        logic [6:0] win_cnt;
        logic [6:0] xtal_cnt;
        logic [1:0] settle;
        logic too_low;
        logic [5:0] ref_cnt;
        logic [6:0] fb_cnt;
        logic [2:0] good_wins;
        logic lock;
        logic lock_seen;
        logic bypass;
        logic disc;
        logic [3:0] fb_div;
        logic [1:0] ref_src;
        logic range;
        logic [1:0] sys_src;
        logic [3:0] slow_div;
        logic osc_flag;
        logic loop_flag;
        logic osc_pend;
        logic loop_pend;
        logic waking;
        logic periph_a;
        pscc_pkg::pscc_boot_type boot;
    } pscc_state_type;

    pscc_state_type s_q;
    pscc_state_type s_d;

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction : rise

    logic int_edge;
    logic xtal_edge;
    logic fb_edge;
    logic on_sys;
    logic osc_event;
    logic lock_loss;
    logic osc_case;

    always_comb begin
        s_d = s_q;
        s_d.last = sync2_q;
        int_edge = rise(sync2_q[0], s_q.last[0]);
        xtal_edge = rise(sync2_q[1], s_q.last[1]);
        fb_edge = rise(sync2_q[2], s_q.last[2]);
        on_sys = (s_q.sys_src == pscc_pkg::SRC_LOOP);
        osc_event = 1'b0;
        lock_loss = 1'b0;

        // Oscillator watchdog, timed by internal oscillator
        if (xtal_edge && s_q.xtal_cnt != 7'h7F) begin
            s_d.xtal_cnt = s_q.xtal_cnt + 7'h01;
        end
        if (int_edge) begin
            if (s_q.win_cnt == 7'(pscc_pkg::WATCH_WIN - 1)) begin
                s_d.win_cnt = 7'h00;
                s_d.xtal_cnt = 7'h00;
                if (s_q.settle != 2'(pscc_pkg::WATCH_SETTLE)) begin
                    s_d.settle = s_q.settle + 2'h1;
                end else begin
                    s_d.too_low = (s_q.xtal_cnt < 7'(pscc_pkg::OSC_MIN_EDGES));
                    osc_event = ~s_q.too_low & s_d.too_low;
                end
            end else begin
                s_d.win_cnt = s_q.win_cnt + 7'h01;
            end
        end
        if (osc_watch_restart) begin
            // Too-low held set until detection is valid again
            s_d.too_low = 1'b1;
            s_d.settle = 2'h0;
            s_d.win_cnt = 7'h00;
            s_d.xtal_cnt = 7'h00;
        end

        // Lock detector: feedback edges counted per reference window
        if (fb_edge && s_q.fb_cnt != 7'h7F) begin
            s_d.fb_cnt = s_q.fb_cnt + 7'h01;
        end
        if (s_q.ref_src == pscc_pkg::REF_XTAL ? xtal_edge : int_edge) begin
            if (s_q.ref_cnt == 6'(pscc_pkg::LOCK_WIN - 1)) begin
                s_d.ref_cnt = 6'h00;
                s_d.fb_cnt = 7'h00;
                if (s_q.fb_cnt + 7'(pscc_pkg::LOCK_TOL) < 7'(pscc_pkg::LOCK_WIN)
                    || s_q.fb_cnt > 7'(pscc_pkg::LOCK_WIN + pscc_pkg::LOCK_TOL)) begin
                    s_d.good_wins = 3'h0;
                    s_d.lock = 1'b0;
                    lock_loss = s_q.lock;
                end else if (s_q.good_wins != 3'(pscc_pkg::LOCK_GOOD_WINS)) begin
                    s_d.good_wins = s_q.good_wins + 3'h1;
                end else begin
                    s_d.lock = 1'b1;
                    s_d.lock_seen = 1'b1;
                end
            end else begin
                s_d.ref_cnt = s_q.ref_cnt + 6'h01;
            end
        end
        if (lock_detect_restart) begin
            s_d.lock = 1'b0;
            s_d.good_wins = 3'h0;
            s_d.ref_cnt = 6'h00;
            s_d.fb_cnt = 7'h00;
        end

        // Software configuration writes
        if (wr_en && wr_bypass) begin
            s_d.bypass = wr_bypass_val;
            if (wr_bypass_val) begin
                s_d.disc = 1'b0;
            end
        end
        if (wr_en && wr_feedback) begin
            s_d.fb_div = wr_feedback_val;
        end
        if (wr_en && wr_ref_src) begin
            s_d.ref_src = wr_ref_src_val;
        end
        if (wr_en && wr_range) begin
            s_d.range = wr_range_val;
        end
        if (wr_en && wr_slow) begin
            s_d.slow_div = wr_slow_val;
        end
        if (wr_en && wr_sys_src) begin
            s_d.sys_src = wr_sys_src_val;
        end

        // Trap flags; set wins over clear
        osc_case = (s_q.bypass && s_q.ref_src == pscc_pkg::REF_XTAL && on_sys)
            || s_q.sys_src == pscc_pkg::SRC_XTAL;
        if (osc_trap_clear) begin
            s_d.osc_flag = 1'b0;
        end
        if (osc_event && osc_case) begin
            s_d.osc_flag = 1'b1;
        end
        if (loop_trap_clear) begin
            s_d.loop_flag = 1'b0;
        end
        if (lock_loss && on_sys && !s_q.bypass && s_q.lock_seen) begin
            s_d.loop_flag = 1'b1;
        end
        // In bypass: lock flag clear only, done above; off system path, lock loss still forces freerun below
        s_d.osc_pend = osc_event && osc_case && osc_trap_enable;
        s_d.loop_pend = lock_loss && on_sys && !s_q.bypass && s_q.lock_seen && loop_trap_enable;

        // Forced freerunning
        if ((osc_event && s_q.bypass && s_q.ref_src == pscc_pkg::REF_XTAL)
            || (lock_loss && !s_q.bypass)) begin
            s_d.disc = 1'b1;
            s_d.bypass = 1'b0;
            if (s_q.sys_src == pscc_pkg::SRC_XTAL) begin
                s_d.sys_src = pscc_pkg::SRC_LOOP;
            end
        end

        // Startup source control
        unique case (s_q.boot)
            pscc_pkg::ST_BOOT: begin
                s_d.sys_src = pscc_pkg::SRC_LP;
                s_d.boot = pscc_pkg::ST_WAIT_LOCK;
            end
            pscc_pkg::ST_WAIT_LOCK: begin
                if (s_q.lock) begin
                    s_d.sys_src = pscc_pkg::SRC_LOOP;
                    s_d.disc = 1'b0;
                    s_d.boot = pscc_pkg::ST_RUN;
                end else begin
                    s_d.sys_src = pscc_pkg::SRC_LP;
                end
            end
            pscc_pkg::ST_RUN: begin
            end
        endcase

        // Wake-up restore
        if (wake_up) begin
            s_d.waking = 1'b1;
            s_d.periph_a = 1'b0;
        end else if (s_q.waking && s_q.lock) begin
            s_d.waking = 1'b0;
            s_d.periph_a = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.too_low <= 1'b1;
            s_q.disc <= 1'b1;
            s_q.fb_div <= pscc_pkg::FB_DIV_RST;
            s_q.ref_src <= pscc_pkg::REF_INT;
            s_q.sys_src <= pscc_pkg::SRC_LP;
            s_q.slow_div <= pscc_pkg::SLOW_DIV_RST;
            s_q.periph_a <= 1'b1;
            s_q.boot <= pscc_pkg::ST_BOOT;
        end else if (!cold_rst_n) begin
            // Only cold resets restart boot; warm resets never reach here
            s_q.boot <= pscc_pkg::ST_BOOT;
            s_q.sys_src <= pscc_pkg::SRC_LP;
        end else begin
            s_q <= s_d;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign osc_too_low_flag = s_q.too_low;
    assign lock_flag = s_q.lock;
    assign vco_bypass_select = s_q.bypass;
    assign osc_disconnect = s_q.disc;
    assign freerun_active = !s_q.bypass && (s_q.disc || !s_q.lock);
    assign feedback_divider_field = s_q.fb_div;
    assign ref_src_sel = s_q.ref_src;
    assign vco_range_select = s_q.range;
    assign sys_clock_source_sel = s_q.sys_src;
    assign slowdown_divider = s_q.slow_div;
    assign osc_trap_flag = s_q.osc_flag;
    assign loop_trap_flag = s_q.loop_flag;
    assign osc_trap = s_q.osc_pend;
    assign loop_trap = s_q.loop_pend;
    assign lock_detect_restart_rd = 1'b0;
    assign cpu_div_sel = slowdown_enable ? s_q.slow_div : 4'h0;
    assign periph_clock_b_en = 1'b1;
    assign memory_clock_en = 1'b1;
    assign periph_clock_a_en = s_q.periph_a;
endmodule : pscc_top
`default_nettype wire

// ===== dv/pscc_top_asserts.sv
// Purpose: Port checks for pscc_top
// Assumes: One clock domain, async reset low
// Notes: Bound to every pscc_top instance
`default_nettype none
// ****************
// Checker
// ****************
module pscc_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic wr_bypass,
    input wire logic wr_bypass_val,
    input wire logic lock_detect_restart,
    input wire logic slowdown_enable,
    input wire logic wake_up,
    input wire logic lock_flag,
    input wire logic vco_bypass_select,
    input wire logic osc_disconnect,
    input wire logic freerun_active,
    input wire logic [1:0] sys_clock_source_sel,
    input wire logic [3:0] slowdown_divider,
    input wire logic osc_trap_flag,
    input wire logic loop_trap_flag,
    input wire logic osc_trap,
    input wire logic loop_trap,
    input wire logic lock_detect_restart_rd,
    input wire logic [3:0] cpu_div_sel,
    input wire logic periph_clock_a_en,
    input wire logic periph_clock_b_en,
    input wire logic memory_clock_en
);
    logic seen_q;
    logic seen_d;
    // Lock seen once since reset
    assign seen_d = seen_q | lock_flag;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) seen_q <= 1'h0;
        else seen_q <= seen_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_restart_reads_zero: assert property (lock_detect_restart_rd == 1'h0)
        else $error("lock restart bit read back nonzero");
    a_restart_drops_lock: assert property (lock_detect_restart |=> !lock_flag)
        else $error("lock flag kept after restart");
    a_bypass_ends_freerun: assert property (wr_en && wr_bypass && wr_bypass_val |=>
        vco_bypass_select && !osc_disconnect && !freerun_active) else $error("bypass write not taken");
    a_freerun_no_bypass: assert property ($rose(osc_disconnect) |-> !vco_bypass_select && freerun_active)
        else $error("forced freerun kept bypass set");
    a_loop_trap_cause: assert property ($rose(loop_trap_flag) |-> seen_q &&
        $past(sys_clock_source_sel) == 2'h0 && !$past(vco_bypass_select)) else $error("loop trap without cause");
    a_loop_trap_pulse: assert property (loop_trap |-> loop_trap_flag ##1 !loop_trap)
        else $error("loop trap pulse malformed");
    a_osc_trap_pulse: assert property (osc_trap |-> osc_trap_flag ##1 !osc_trap)
        else $error("osc trap pulse malformed");
    a_slow_off_full: assert property (!slowdown_enable |-> cpu_div_sel == 4'h0)
        else $error("divider active while slowdown off");
    a_slow_on_div: assert property (slowdown_enable |-> cpu_div_sel == slowdown_divider)
        else $error("slowdown divider not applied");
    a_boot_low_power: assert property (!seen_q && !lock_flag |-> sys_clock_source_sel == 2'h2)
        else $error("left low power clock before lock");
    a_clocks_equal: assert property (periph_clock_b_en && memory_clock_en)
        else $error("peripheral or memory clock gated");
    a_wake_periph_hold: assert property (wake_up |=> !periph_clock_a_en && periph_clock_b_en)
        else $error("wake restore order wrong");
    c_loop_trap: cover property (loop_trap_flag);
    c_osc_trap: cover property (osc_trap_flag);
    c_bypass_loss: cover property ($fell(lock_flag) && vco_bypass_select);
endmodule : pscc_chk
bind pscc_top pscc_chk u_chk (.*);
`default_nettype wire

// ===== dv/pscc_top_tb.sv
// Purpose: Self-checking bench for pscc_top
// Assumes: 200 MHz ref_clk, oscillator levels made here
// Notes: Oscillators toggle every 20 cycles, 5 MHz
`default_nettype none
// ****************
// Bench
// ****************
module pscc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'h0, arst_n = 1'h0, cold_rst_n = 1'h1, int_osc_in = 1'h0, xtal_osc_in = 1'h0, fb_clk_in = 1'h0;
    logic wr_en = 1'h0, wr_bypass, wr_bypass_val, wr_feedback, wr_ref_src, wr_range, wr_range_val, wr_sys_src;
    logic wr_slow, slowdown_enable = 1'h0, osc_watch_restart, lock_detect_restart, osc_trap_clear, loop_trap_clear;
    logic osc_trap_enable = 1'h0, loop_trap_enable = 1'h0, wake_up, fb_run = 1'h0, x_run = 1'h0;
    logic [3:0] wr_feedback_val, wr_slow_val, val = 4'h0, st;
    logic [1:0] wr_ref_src_val, wr_sys_src_val;
    logic [5:0] sel = 6'h0;
    logic [4:0] pul = 5'h0;
    logic osc_too_low_flag, lock_flag, vco_bypass_select, osc_disconnect, freerun_active, vco_range_select;
    logic osc_trap_flag, loop_trap_flag, osc_trap, loop_trap, lock_detect_restart_rd;
    logic periph_clock_a_en, periph_clock_b_en, memory_clock_en;
    logic [3:0] feedback_divider_field, slowdown_divider, cpu_div_sel;
    logic [1:0] ref_src_sel, sys_clock_source_sel;
    int div = 0, error_cnt = 0, cmp_count = 0;
    assign {wr_slow, wr_sys_src, wr_range, wr_ref_src, wr_feedback, wr_bypass} = sel;
    assign {wake_up, loop_trap_clear, osc_trap_clear, lock_detect_restart, osc_watch_restart} = pul;
    assign wr_bypass_val = val[0];
    assign wr_range_val = val[0];
    assign wr_feedback_val = val;
    assign wr_slow_val = val;
    assign wr_ref_src_val = val[1:0];
    assign wr_sys_src_val = val[1:0];
    assign st = {osc_trap_flag, loop_trap_flag, osc_too_low_flag, lock_flag};
    pscc_top uut (.*);
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        div <= (div == 19) ? 0 : div + 1;
        if (div == 19) begin
            int_osc_in <= ~int_osc_in;
            if (fb_run) fb_clk_in <= ~fb_clk_in;
            if (x_run) xtal_osc_in <= ~xtal_osc_in;
        end
    end
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [3:0] s, input logic [3:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input int k, input logic [3:0] v);
        @(posedge ref_clk);
        wr_en <= 1'h1;
        sel <= 6'h1 << k;
        val <= v;
        @(posedge ref_clk);
        wr_en <= 1'h0;
        sel <= 6'h0;
        @(negedge ref_clk);
    endtask : wr
    task automatic pulse(input int k);
        @(posedge ref_clk);
        pul <= 5'h1 << k;
        @(posedge ref_clk);
        pul <= 5'h0;
        @(negedge ref_clk);
    endtask : pulse
    task automatic wait_for(input int k, input logic v);
        int n;
        n = 0;
        while (st[k] !== v && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        if (st[k] !== v) begin
            error_cnt++;
            $display("unexpected at %0t: wait on status %0d timed out", $time, k);
            conclude();
        end
    endtask : wait_for
    task automatic endt(input string s);
        $display("test %s done", s);
    endtask : endt
    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(negedge ref_clk);
        chk({osc_too_low_flag, osc_disconnect, lock_flag, vco_bypass_select}, 4'hC);
        chk(feedback_divider_field, pscc_pkg::FB_DIV_RST);
        chk({osc_trap_flag, loop_trap_flag, ref_src_sel}, {2'h0, pscc_pkg::REF_INT});
        wr(4, 4'h1);
        chk(sys_clock_source_sel, pscc_pkg::SRC_LP);
        fb_run <= 1'h1;
        wait_for(0, 1'h1);
        repeat (2) @(negedge ref_clk);
        chk({osc_disconnect, freerun_active, sys_clock_source_sel}, {2'h0, pscc_pkg::SRC_LOOP});
        endt("startup");
        wr(5, 4'h3);
        chk(cpu_div_sel, 4'h0);
        @(posedge ref_clk);
        slowdown_enable <= 1'h1;
        @(negedge ref_clk);
        chk(cpu_div_sel, 4'h3);
        pulse(4);
        chk({periph_clock_a_en, periph_clock_b_en, memory_clock_en}, 4'h3);
        @(negedge ref_clk);
        chk({periph_clock_a_en, periph_clock_b_en, memory_clock_en}, 4'h7);
        endt("slowdown and wake");
        @(posedge ref_clk);
        loop_trap_enable <= 1'h1;
        fb_run <= 1'h0;
        wait_for(2, 1'h1);
        chk({lock_flag, freerun_active, vco_bypass_select}, 4'h2);
        wr(0, 4'h1);
        chk({vco_bypass_select, osc_disconnect, freerun_active}, 4'h4);
        wr(1, 4'h8);
        chk(feedback_divider_field, 4'h8);
        wr(3, 4'h1);
        chk(vco_range_select, 4'h1);
        wr(2, {2'h0, pscc_pkg::REF_INT});
        chk(ref_src_sel, pscc_pkg::REF_INT);
        fb_run <= 1'h1;
        pulse(1);
        chk(lock_flag, 4'h0);
        wait_for(0, 1'h1);
        wr(0, 4'h0);
        pulse(3);
        chk({loop_trap_flag, vco_bypass_select, freerun_active}, 4'h0);
        endt("loop loss recovery");
        wr(0, 4'h1);
        fb_run <= 1'h0;
        wait_for(0, 1'h0);
        repeat (50) @(negedge ref_clk);
        chk(loop_trap_flag, 4'h0);
        fb_run <= 1'h1;
        pulse(1);
        wait_for(0, 1'h1);
        wr(0, 4'h0);
        endt("prescaler loss");
        x_run <= 1'h1;
        pulse(0);
        wait_for(1, 1'h0);
        chk(osc_too_low_flag, 4'h0);
        @(posedge ref_clk);
        osc_trap_enable <= 1'h1;
        wr(4, 4'h1);
        chk(sys_clock_source_sel, pscc_pkg::SRC_XTAL);
        x_run <= 1'h0;
        wait_for(3, 1'h1);
        chk(osc_too_low_flag, 4'h1);
        endt("oscillator watch");
        x_run <= 1'h1;
        pulse(0);
        wait_for(1, 1'h0);
        wr(0, 4'h1);
        pulse(1);
        wait_for(0, 1'h1);
        wr(0, 4'h0);
        pulse(2);
        chk({osc_trap_flag, osc_too_low_flag, vco_bypass_select}, 4'h0);
        endt("oscillator trap recovery");
        wr(0, 4'h1);
        wr(2, {2'h0, pscc_pkg::REF_XTAL});
        x_run <= 1'h0;
        wait_for(3, 1'h1);
        chk({osc_disconnect, vco_bypass_select, sys_clock_source_sel}, {2'h2, pscc_pkg::SRC_LOOP});
        endt("prescaler oscillator loss");
        @(posedge ref_clk);
        cold_rst_n <= 1'h0;
        @(posedge ref_clk);
        cold_rst_n <= 1'h1;
        @(negedge ref_clk);
        chk(feedback_divider_field, 4'h8);
        chk(sys_clock_source_sel, pscc_pkg::SRC_LP);
        repeat (2) @(negedge ref_clk);
        chk(sys_clock_source_sel, pscc_pkg::SRC_LOOP);
        endt("cold restart");
        conclude();
    end
endmodule : pscc_top_tb
`default_nettype wire
